// File: pkg/pwbs_pkg.sv
// Purpose: shared constants of the single-wire brightness step decoder
// Assumes: 40 MHz core clock, one combined enable/programming wire
// Notes:   times are kept in their printed units; cycle counts derive here
`default_nettype none

package pwbs_pkg;

	// core clock
	localparam int unsigned CLK_HZ        = 40_000_000; // 40 MHz
	localparam int unsigned CLK_PERIOD_NS = 25;         // 25 ns

	// step counter layout
	localparam int unsigned CODE_W    = 5;        // 32 codes
	localparam logic [4:0]  CODE_CTR  = 5'h10;    // centre, 250 mV reference
	localparam logic [4:0]  CODE_MAX  = 5'h1F;    // top code
	localparam logic [4:0]  CODE_MIN  = 5'h00;    // bottom code
	localparam int unsigned STEP_UV   = 15_600;   // reference change per code

	// printed pulse times
	localparam int unsigned UP_MIN_US   = 1;      // increase, least
	localparam int unsigned UP_MAX_US   = 75;     // increase, longest
	localparam int unsigned DN_MIN_US   = 180;    // decrease, least
	localparam int unsigned DN_MAX_US   = 300;    // decrease, longest
	localparam int unsigned OFF_MIN_US  = 550;    // setting discarded
	localparam int unsigned SHUT_MIN_MS = 50;     // full shutdown

	// least times round up, longest times round down
	localparam int unsigned UP_MIN_CYC =
		(UP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UP_MAX_CYC = (UP_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned DN_MIN_CYC =
		(DN_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DN_MAX_CYC = (DN_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned OFF_CYC =
		(OFF_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SHUT_CYC = SHUT_MIN_MS * (CLK_HZ / 1000);

	// low-time counter wide enough for the shutdown count
	localparam int unsigned LOW_W = 22;

	// wire decoder states, one-hot
	typedef enum logic [3:0] {
		PWBS_OFF   = 4'h1, // shut down, internals idle
		PWBS_RUN   = 4'h2, // wire high, converter switching
		PWBS_PAUSE = 4'h4, // wire low, setting kept
		PWBS_BLANK = 4'h8  // wire low long, setting discarded
	} pwbs_state_t;

endpackage : pwbs_pkg

`default_nettype wire

// File: rtl/pwbs_sync.sv
// Purpose: bring the wire into the clock domain and debounce by agreement
// Assumes: input is asynchronous to clk
// Notes:   the level only moves once the 2nd and 3rd stages agree
`default_nettype none

module pwbs_sync (
	input  wire logic clk,      // core clock
	input  wire logic rst_b,    // synchronous reset, active low
	input  wire logic pin,      // raw wire level
	output var  logic level     // settled level
);
	import pwbs_pkg::*;

	logic s1; // first stage, read only by s2
	logic s2; // second stage
	logic s3; // third stage

	// three-stage chain; reset reads the wire as low (device off)
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			// a one-cycle glitch on s2 never reaches level
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end

endmodule : pwbs_sync

`default_nettype wire

// File: rtl/pwbs_stepper.sv
// Purpose: decode low-pulse widths on the enable/programming wire into a
//          5-bit feedback reference step code
// Assumes: 40 MHz clock; wire synchronised internally; reset = power-up
// Notes:   widths are measured on the settled level, so both edges carry
//          the same synchroniser lag and widths are not skewed
`default_nettype none

// Overview of operation
// - shut down only after 50 ms low
// - short low stops switching, internals stay active
// - enabling loads the centre code, 250 mV
// - fifteen steps up and sixteen down from centre
// - low over 550 us discards the setting
// - 32 codes of 15.6 mV each
// - code holds until reprogrammed
// - short low increments, medium low decrements
// - 1 kHz enable dimming never shuts down
module pwbs_stepper #(
	parameter int unsigned DN_MIN_CYCLES = pwbs_pkg::DN_MIN_CYC, // 180 us
	parameter int unsigned DN_MAX_CYCLES = pwbs_pkg::DN_MAX_CYC, // 300 us
	parameter int unsigned OFF_CYCLES    = pwbs_pkg::OFF_CYC,    // 550 us
	parameter int unsigned SHUT_CYCLES   = pwbs_pkg::SHUT_CYC    // 50 ms
) (
	input  wire logic        clk,                      // 40 MHz
	input  wire logic        rst_b,                    // sync, active low
	input  wire logic        current_program_pin,      // raw wire
	output var  logic [4:0]  feedback_reference_level, // step code
	output logic             switch_en,                // converter runs
	output logic             internal_active,          // not shut down
	output logic             step_up_pulse,            // code went up
	output logic             step_down_pulse           // code went down
);
	import pwbs_pkg::*;

	logic             wire_lvl;   // settled wire level
	logic             wire_q;     // settled level, one cycle late
	logic [LOW_W-1:0] low_cnt;    // cycles the wire has been low
	logic [LOW_W-1:0] next_low_cnt;
	pwbs_state_t      state;      // decoder state
	pwbs_state_t      next_state;
	logic [4:0]       next_level; // next step code
	logic             up_q;       // registered step strobes
	logic             dn_q;

	// the pin is asynchronous, so it passes the agreement synchroniser
	pwbs_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (current_program_pin),
		.level (wire_lvl)
	);

	// decoded conditions, all continuous
	wire in_off   = (state == PWBS_OFF);
	wire in_run   = (state == PWBS_RUN);
	wire in_pause = (state == PWBS_PAUSE);
	wire in_blank = (state == PWBS_BLANK);
	wire rise     = wire_lvl & ~wire_q;            // end of a low pulse
	wire low_sat  = (low_cnt == {LOW_W{1'b1}});    // counter parked
	wire off_hit  = ~wire_lvl & (low_cnt >= LOW_W'(OFF_CYCLES));
	wire shut_hit = ~wire_lvl & (low_cnt >= LOW_W'(SHUT_CYCLES));
	wire is_up    = (low_cnt >= LOW_W'(UP_MIN_CYC)) &&
	                (low_cnt <= LOW_W'(UP_MAX_CYC));
	wire is_dn    = (low_cnt >= LOW_W'(DN_MIN_CYCLES)) &&
	                (low_cnt <= LOW_W'(DN_MAX_CYCLES));
	// steps only count for a pulse short enough to keep the setting
	wire take_up  = rise & in_pause & is_up &
	                (feedback_reference_level != CODE_MAX);
	wire take_dn  = rise & in_pause & is_dn &
	                (feedback_reference_level != CODE_MIN);
	wire go_blank = in_pause & off_hit;
	// one code up or down; the carry out is dropped on purpose, since
	// saturation already keeps the step from reaching past either end
	wire [4:0] code_inc = 5'(feedback_reference_level + 5'h01);
	wire [4:0] code_dec = 5'(feedback_reference_level - 5'h01);

	// low time: restart when high, stop at the top instead of wrapping
	assign next_low_cnt = wire_lvl ? '0 :
	                      (low_sat ? low_cnt : low_cnt + LOW_W'(1));

	// step code: discard on long low, else one step per decoded pulse;
	// widths in neither window fall through and leave the code alone
	assign next_level = go_blank ? CODE_CTR :
	                    in_off   ? CODE_CTR :
	                    take_up  ? code_inc :
	                    take_dn  ? code_dec :
	                    feedback_reference_level;

	// converter only switches while the wire is high and awake
	assign switch_en       = in_run;
	assign internal_active = ~in_off;
	assign step_up_pulse   = up_q;
	assign step_down_pulse = dn_q;

	// state transitions
	always_comb begin
		next_state = state;
		case (state)
			PWBS_OFF: begin
				if (wire_lvl) begin
					next_state = PWBS_RUN;
				end
			end
			PWBS_RUN: begin
				if (!wire_lvl) begin
					next_state = PWBS_PAUSE;
				end
			end
			PWBS_PAUSE: begin
				if (wire_lvl) begin
					next_state = PWBS_RUN;
				end else if (off_hit) begin
					next_state = PWBS_BLANK;
				end
			end
			PWBS_BLANK: begin
				if (wire_lvl) begin
					next_state = PWBS_RUN;
				end else if (shut_hit) begin
					next_state = PWBS_OFF;
				end
			end
			default: begin
				next_state = PWBS_OFF;  // illegal code recovers to off
			end
		endcase
	end

	// state and level registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state                    <= PWBS_OFF;
			feedback_reference_level <= CODE_CTR;
		end else begin
			state                    <= next_state;
			feedback_reference_level <= next_level;
		end
	end

	// edge history, low timer and step strobes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wire_q  <= 1'b0;
			low_cnt <= '0;
			up_q    <= 1'b0;
			dn_q    <= 1'b0;
		end else begin
			wire_q  <= wire_lvl;
			low_cnt <= next_low_cnt;
			up_q    <= take_up;
			dn_q    <= take_dn;
		end
	end

	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_SHUT_ONLY_LONG: assert property (
		$rose(in_off) |-> $past(low_cnt) >= LOW_W'(SHUT_CYCLES))
		else $error("shutdown entered before the long low time");

	AST_SHUT_ON_TIME: assert property (
		(in_blank && shut_hit) |=> in_off && !internal_active)
		else $error("long low did not shut the device down");

	AST_LOW_NO_SWITCH: assert property (
		(!wire_lvl && !in_off && !shut_hit) |=>
			!switch_en && internal_active)
		else $error("converter switched during a short low");

	AST_ENABLE_CENTRE: assert property (
		($past(in_off) && in_run) |-> feedback_reference_level == CODE_CTR)
		else $error("enable did not start at the centre code");

	AST_DISCARD: assert property (
		in_blank |-> feedback_reference_level == CODE_CTR)
		else $error("setting kept after a long low");

	AST_HOLD: assert property (
		(!rise && !go_blank && !in_off) |=> $stable(feedback_reference_level))
		else $error("code changed without a pulse");

	AST_UP_STEP: assert property (
		take_up |=> ((feedback_reference_level ==
			5'($past(feedback_reference_level) + 5'h01)) && step_up_pulse)
			##1 !step_up_pulse)
		else $error("increase pulse not applied once");

	AST_DN_STEP: assert property (
		take_dn |=> (feedback_reference_level ==
			5'($past(feedback_reference_level) - 5'h01)) && step_down_pulse)
		else $error("decrease pulse not applied");

	AST_PWM_AWAKE: assert property (
		(in_run ##1 (!wire_lvl)[*8]) |-> internal_active && !in_off)
		else $error("short low caused shutdown");

	AST_SATURATE: assert property (
		(rise && feedback_reference_level == CODE_MAX && is_up) |=>
			feedback_reference_level == CODE_MAX)
		else $error("code wrapped past the top");

	AST_GAP_IGNORED: assert property (
		(rise && in_pause && !is_up && !is_dn) |=>
			$stable(feedback_reference_level))
		else $error("width between windows changed the code");

	COV_UP_TO_MAX: cover property (
		step_up_pulse && feedback_reference_level == CODE_MAX);
	COV_DN_TO_MIN: cover property (
		step_down_pulse && feedback_reference_level == CODE_MIN);
	COV_DISCARD: cover property ($rose(in_blank));
	COV_SHUTDOWN: cover property ($rose(in_off));

endmodule : pwbs_stepper

`default_nettype wire

// File: test/pwbs_host.sv
// Purpose: host model that drives the programming wire
// Assumes: shares the 40 MHz core clock with the device
// Notes:   levels change only just after a rising edge
`default_nettype none

module pwbs_host (
	input  wire logic clk, // core clock
	output var  logic pin  // wire to the device
);
	timeunit 1ns;
	timeprecision 1ps;

	// low from time zero so the device stays off through reset
	initial pin = 1'b0;

	// hold one level for n cycles; callers build start, step and gap;
	// the level moves on a rising edge, and the task returns at the
	// falling edge so callers read settled outputs, never the edge itself
	task automatic drive(input logic v, input int n);
		@(posedge clk);
		pin <= v;
		repeat (n - 1) @(posedge clk);
		@(negedge clk);
	endtask : drive

endmodule : pwbs_host

`default_nettype wire

// File: test/pwbs_stepper_tb.sv
// Purpose: self-checking bench for the wire width decoder
// Assumes: shortened decrease, discard and shutdown counts
// Notes:   pulse widths come from an lfsr seeded with a fixed value
`default_nettype none

module pwbs_stepper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pwbs_pkg::*;

	// shortened counts keep the run short; order up < down < off kept
	localparam int DMIN = 3200;
	localparam int DMAX = 3400;
	localparam int OFFC = 4000;
	localparam int SHUTC = 6000;

	logic        clk;          // core clock
	logic        rst_b;        // reset, active low
	wire logic   pin;          // wire from host model
	logic [4:0]  lvl;          // step code seen
	logic        sw;           // converter switching
	logic        act;          // internals alive
	logic        up;           // increase seen
	logic        dn;           // decrease seen
	int          err_count;    // mismatches
	int          total_checks; // comparisons
	int          cyc;          // cycle count for the timeout
	int          n_up;         // increase pulses seen
	int          n_dn;         // decrease pulses seen
	int          exp_up;       // increase pulses expected
	int          exp_dn;       // decrease pulses expected
	logic [15:0] seed;         // lfsr state
	logic [4:0]  exp_lvl;      // expected step code

	pwbs_host host_u (.clk(clk), .pin(pin));

	pwbs_stepper #(.DN_MIN_CYCLES(DMIN), .DN_MAX_CYCLES(DMAX),
		.OFF_CYCLES(OFFC), .SHUT_CYCLES(SHUTC)) dut_u (
		.clk(clk), .rst_b(rst_b), .current_program_pin(pin),
		.feedback_reference_level(lvl), .switch_en(sw),
		.internal_active(act), .step_up_pulse(up),
		.step_down_pulse(dn));

	// free-running clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// pulse counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (up) n_up <= n_up + 1;
		if (dn) n_dn <= n_dn + 1;
		if (cyc == 100000) begin
			err_count++;
			finish_test();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// code after one low pulse of n cycles; saturates, never wraps
	function automatic logic [4:0] next_code(input logic [4:0] c,
		input int n);
		if (n >= UP_MIN_CYC && n <= UP_MAX_CYC && c != CODE_MAX)
			return c + 5'h01;
		if (n >= DMIN && n <= DMAX && c != CODE_MIN)
			return c - 5'h01;
		return c;
	endfunction : next_code

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %0h seen %0h", name, exp, seen);
		end
	endtask : check

	// one low pulse, then a gap above the 60-cycle minimum
	task automatic step(input int n);
		logic [4:0] nx;
		nx = next_code(exp_lvl, n);
		if (nx > exp_lvl) exp_up++;
		if (nx < exp_lvl) exp_dn++;
		exp_lvl = nx;
		host_u.drive(1'b0, n);
		check("switch", {31'h0, sw}, 32'h0);
		check("active", {31'h0, act}, 32'h1);
		host_u.drive(1'b1, 80);
		check("level", {27'h0, lvl}, {27'h0, exp_lvl});
	endtask : step

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		n_up = 0;
		n_dn = 0;
		exp_up = 0;
		exp_dn = 0;
		seed = 16'h45D5;
		exp_lvl = CODE_CTR;
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		check("level", {27'h0, lvl}, 32'h10);
		check("active", {31'h0, act}, 32'h0);
		host_u.drive(1'b1, 4000);
		check("switch", {31'h0, sw}, 32'h1);
		check("active", {31'h0, act}, 32'h1);
		// widths just outside each window change nothing
		step(39);
		step(3001);
		step(3199);
		step(3401);
		// increases: corners first, then random, past the top code
		for (int i = 0; i < 18; i++) begin
			step(i == 0 ? 40 : i == 1 ? 3000 : 40 + seed % 200);
			seed = lfsr(seed);
		end
		check("ups", n_up, exp_up);
		// long low discards the setting but keeps internals alive
		host_u.drive(1'b0, OFFC + 10);
		check("level", {27'h0, lvl}, 32'h10);
		check("active", {31'h0, act}, 32'h1);
		host_u.drive(1'b1, 4000);
		exp_lvl = CODE_CTR;
		// decreases down to the bottom code and one beyond
		for (int i = 0; i < 17; i++) begin
			step(i == 0 ? DMIN : i == 1 ? DMAX : DMIN + seed % 50);
			seed = lfsr(seed);
		end
		check("downs", n_dn, exp_dn);
		host_u.drive(1'b1, 500);
		check("level", {27'h0, lvl}, 32'h0);
		// full shutdown, then enabling reloads the centre code
		host_u.drive(1'b0, SHUTC + 10);
		check("active", {31'h0, act}, 32'h0);
		host_u.drive(1'b1, 100);
		check("level", {27'h0, lvl}, 32'h10);
		check("active", {31'h0, act}, 32'h1);
		finish_test();
	end

endmodule : pwbs_stepper_tb

`default_nettype wire
